// file: rtl/dac_input_port.sv
// Input port capture, pairing, clock outputs and zero stuffing
// Notes on behaviour
// - Multiplier on, dual port: capture every input clock
// - Control bit picks lock or clock on pin
// - Multiplier on: clock out matches input clock
// - Dual port feeds filters at port rate
// - Output rate is input times interpolation, stuffing
// - Invert bit flips sample clock output only
// - Single port interleaves on port A, 2x clock
// - Channel select low means I, high Q
// - Invert bit swaps channel select meaning
// - No 1x interpolation in single port
// - Invert bit flips interleaved clock output only
// - Pairing bit: I then Q, or Q then I
// - Divide clock by rate, twice with stuffing
// - Multiplier off: capture on divided clock edge
// - Routing bit moves clock to serial out pin
// - Multiplier off, single port: divided interleaved clock
// - Three half-band stages, two-bit rate field
// - Rate codes 00 off, 2x, 4x, 8x
// - Stuffing inserts midscale after each sample
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`default_nettype none
module dac_input_port
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rstn,
  // Register bus, write
  input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // Register bus, read
  input  wire logic [ADDR_W-1:0]          s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Input pins
  input  wire logic [15:0]                port_a_data,
  input  wire logic [15:0]                port_b_data,
  input  wire logic                       converter_clock_input,
  input  wire logic                       channel_select,
  input  wire logic                       pll_lock,
  // Output pins
  output logic                            sample_rate_clock_out,
  output logic                            interleaved_clock_out,
  output logic                            sdo_out,
  output logic                            sdo_oe,
  // Filter inputs
  output logic [15:0]                     filt_i,
  output logic [15:0]                     filt_q,
  output logic                            filt_valid,
  output logic [1:0]                      interp_sel,
  output logic [4:0]                      dac_ratio,
  // Chain output and stuffed converter words
  input  wire logic [15:0]                chain_i,
  input  wire logic [15:0]                chain_q,
  input  wire logic                       chain_valid,
  output logic [15:0]                     dac_i,
  output logic [15:0]                     dac_q,
  output logic                            dac_valid
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  sync_if clk_sync ();  // Converter clock pin
  sync_if sel_sync ();  // Channel select pin
  assign clk_sync.raw = converter_clock_input;
  assign sel_sync.raw = channel_select;
  pin_sync u_clk_sync (.clock(clock), .rstn(rstn), .port(clk_sync));
  pin_sync u_sel_sync (.clock(clock), .rstn(rstn), .port(sel_sync));

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave
  logic [7:0]        reg_interp, reg_port, reg_sdo, reg_pll;  // Control
  logic [7:0]        next_interp, next_port, next_sdo, next_pll;
  logic              aw_held, w_held, next_aw_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;    // Held write address
  logic [7:0]        w_byte, next_w_byte;      // Held low byte
  logic              w_lane, next_w_lane;      // Low lane strobe
  logic              bvalid, next_bvalid;
  logic [1:0]        bresp, next_bresp;
  logic              rvalid, next_rvalid;
  logic [1:0]        rresp, next_rresp;
  logic [31:0]       rdata, next_rdata;
  logic [7:0]        status;                   // Live state word
  logic [1:0]        rate_eff;                 // Effective rate code

  // Map an address to an index, or zero when unmapped
  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [5:0] idx;
    idx = 6'(a[ADDR_W-1:2]);
    if (a[1:0] != 2'h0 || a[ADDR_W-1:2] > (ADDR_W-2)'(dac_port_pkg::IDX_STATUS)
        || idx == 6'h00)
    begin
      idx = 6'h00;
    end
    return idx;
  endfunction

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;
  assign status        = {pll_lock, rate_eff, dac_ratio};

  // Take address and data in either order, answer after both
  always_comb
  begin
    next_interp  = reg_interp;
    next_port    = reg_port;
    next_sdo     = reg_sdo;
    next_pll     = reg_pll;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_byte  = w_byte;
    next_w_lane  = w_lane;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    // Address channel
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    // Data channel
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    // Both held: store and respond
    if (aw_held && w_held)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = dac_port_pkg::RESP_OKAY;
      unique case (reg_index(aw_addr))
        dac_port_pkg::IDX_INTERP: if (w_lane) next_interp = w_byte;
        dac_port_pkg::IDX_PORT:   if (w_lane) next_port = w_byte;
        dac_port_pkg::IDX_SDO:    if (w_lane) next_sdo = w_byte;
        dac_port_pkg::IDX_PLL:    if (w_lane) next_pll = w_byte;
        dac_port_pkg::IDX_STATUS: next_bresp = dac_port_pkg::RESP_OKAY;
        default:                  next_bresp = dac_port_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    // Read channel
    if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = dac_port_pkg::RESP_OKAY;
      next_rdata  = 32'h0;
      unique case (reg_index(s_axi_araddr))
        dac_port_pkg::IDX_INTERP: next_rdata[7:0] = reg_interp;
        dac_port_pkg::IDX_PORT:   next_rdata[7:0] = reg_port;
        dac_port_pkg::IDX_SDO:    next_rdata[7:0] = reg_sdo;
        dac_port_pkg::IDX_PLL:    next_rdata[7:0] = reg_pll;
        dac_port_pkg::IDX_STATUS: next_rdata[7:0] = status;
        default:                  next_rresp = dac_port_pkg::RESP_SLVERR;
      endcase
    end
  end

  // Register only
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      reg_interp <= dac_port_pkg::REG_RESET;
      reg_port   <= dac_port_pkg::REG_RESET;
      reg_sdo    <= dac_port_pkg::REG_RESET;
      reg_pll    <= dac_port_pkg::REG_RESET;
      aw_held    <= 1'b0;
      w_held     <= 1'b0;
      aw_addr    <= '0;
      w_byte     <= 8'h00;
      w_lane     <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= 2'h0;
      rvalid     <= 1'b0;
      rresp      <= 2'h0;
      rdata      <= 32'h0;
    end
    else
    begin
      reg_interp <= next_interp;
      reg_port   <= next_port;
      reg_sdo    <= next_sdo;
      reg_pll    <= next_pll;
      aw_held    <= next_aw_held;
      w_held     <= next_w_held;
      aw_addr    <= next_aw_addr;
      w_byte     <= next_w_byte;
      w_lane     <= next_w_lane;
      bvalid     <= next_bvalid;
      bresp      <= next_bresp;
      rvalid     <= next_rvalid;
      rresp      <= next_rresp;
      rdata      <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and rate
  logic       one_port, pll_on, zstuff, is_q;
  logic [4:0] div_cnt, next_div_cnt;  // Divider phase
  logic [4:0] half;                   // Word period in single port
  logic       clk_prev, next_clk_prev;
  logic       clk_rise, clk_fall, pair_tick, word_tick;

  assign one_port = reg_port[dac_port_pkg::ONEPORT_BIT];
  assign pll_on   = reg_pll[dac_port_pkg::PLL_BIT];
  assign zstuff   = reg_interp[dac_port_pkg::ZSTUFF_BIT];
  logic [1:0] rate_code;  // Rate field as written
  assign rate_code = reg_interp[dac_port_pkg::INTERP_LO +: 2];
  assign rate_eff = (one_port && rate_code == dac_port_pkg::RATE_1X) ?
                    dac_port_pkg::RATE_2X : rate_code;
  assign interp_sel = rate_eff;
  // ratio from rate code and stuffing
  assign dac_ratio = 5'h01 << ({1'b0, rate_eff} + {2'h0, zstuff});
  assign half      = dac_ratio >> 1;
  assign clk_rise  = clk_sync.clean && !clk_prev;
  assign clk_fall  = !clk_sync.clean && clk_prev;
  // select level picks channel, optional swap
  assign is_q      = sel_sync.clean ^ reg_port[dac_port_pkg::SELINV_BIT];

  // Capture ticks for every mode
  always_comb
  begin
    next_clk_prev = clk_sync.clean;
    next_div_cnt  = (div_cnt >= dac_ratio - 5'h01) ? 5'h00 : div_cnt + 5'h01;
    if (pll_on)
    begin
      pair_tick = !one_port && clk_rise;
      word_tick = one_port && (clk_rise || clk_fall);
    end
    else
    begin
      pair_tick = !one_port && div_cnt == 5'h00;
      word_tick = one_port && (div_cnt == 5'h00 || div_cnt == half);
    end
  end

  // Register only
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      div_cnt  <= 5'h00;
      clk_prev <= 1'b0;
    end
    else
    begin
      div_cnt  <= next_div_cnt;
      clk_prev <= next_clk_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port capture and pairing
  logic [15:0] a_s1, a_s2, a_s3, b_s1, b_s2, b_s3;  // Pin stages
  logic [15:0] hold_i, hold_q, next_hold_i, next_hold_q;
  logic [15:0] next_filt_i, next_filt_q;
  logic        next_filt_valid;

  // Form a pair per sample and release both halves together
  always_comb
  begin
    next_hold_i     = hold_i;
    next_hold_q     = hold_q;
    next_filt_i     = filt_i;
    next_filt_q     = filt_q;
    next_filt_valid = 1'b0;
    // capture both ports on sample tick
    if (pair_tick)
    begin
      next_filt_i     = a_s3;
      next_filt_q     = b_s3;
      next_filt_valid = 1'b1;
    end
    else if (word_tick)
    begin
      // I first pairs I with next Q
      if (!reg_port[dac_port_pkg::PAIR_BIT])
      begin
        if (!is_q)
        begin
          next_hold_i = a_s3;
        end
        else
        begin
          next_filt_i     = hold_i;
          next_filt_q     = a_s3;
          next_filt_valid = 1'b1;
        end
      end
      // Q first pairs Q with next I
      else
      begin
        if (is_q)
        begin
          next_hold_q = a_s3;
        end
        else
        begin
          next_filt_i     = a_s3;
          next_filt_q     = hold_q;
          next_filt_valid = 1'b1;
        end
      end
    end
  end

  // Register only; both channels on one edge
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      {a_s1, a_s2, a_s3} <= 48'h0;
      {b_s1, b_s2, b_s3} <= 48'h0;
      hold_i             <= 16'h0000;
      hold_q             <= 16'h0000;
      filt_i             <= 16'h0000;
      filt_q             <= 16'h0000;
      filt_valid         <= 1'b0;
    end
    else
    begin
      {a_s1, a_s2, a_s3} <= {port_a_data, a_s1, a_s2};
      {b_s1, b_s2, b_s3} <= {port_b_data, b_s1, b_s2};
      hold_i             <= next_hold_i;
      hold_q             <= next_hold_q;
      filt_i             <= next_filt_i;
      filt_q             <= next_filt_q;
      filt_valid         <= next_filt_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock and lock pins
  logic shared_level, redirect;
  logic next_sample_out, next_word_out, next_sdo_out, next_sdo_oe;

  assign redirect = reg_sdo[dac_port_pkg::SDO_BIT];

  // Pulse on each capture, inverted on request, then routed
  always_comb
  begin
    // one pulse per sample, optional inversion
    shared_level = pair_tick ^ reg_port[dac_port_pkg::DCLKINV_BIT];
    if (pll_on && !reg_interp[dac_port_pkg::CLKSEL_BIT])
    begin
      shared_level = pll_lock;
    end
    next_word_out = word_tick ^ reg_port[dac_port_pkg::WCLKINV_BIT];
    next_sample_out = redirect ? 1'b0 : shared_level;
    next_sdo_out    = redirect ? shared_level : 1'b0;
    next_sdo_oe     = redirect;
  end

  // Register only
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      sample_rate_clock_out <= 1'b0;
      interleaved_clock_out <= 1'b0;
      sdo_out               <= 1'b0;
      sdo_oe                <= 1'b0;
    end
    else
    begin
      sample_rate_clock_out <= next_sample_out;
      interleaved_clock_out <= next_word_out;
      sdo_out               <= next_sdo_out;
      sdo_oe                <= next_sdo_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero stuffing after the chain
  logic        stuff_pend, next_stuff_pend;
  logic [15:0] next_dac_i, next_dac_q;
  logic        next_dac_valid;

  always_comb
  begin
    next_dac_i      = dac_i;
    next_dac_q      = dac_q;
    next_dac_valid  = 1'b0;
    next_stuff_pend = 1'b0;
    if (chain_valid)
    begin
      next_dac_i      = chain_i;
      next_dac_q      = chain_q;
      next_dac_valid  = 1'b1;
      next_stuff_pend = zstuff;
    end
    else if (stuff_pend)
    begin
      next_dac_i     = dac_port_pkg::MIDSCALE;
      next_dac_q     = dac_port_pkg::MIDSCALE;
      next_dac_valid = 1'b1;
    end
  end

  // Register only
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      dac_i      <= 16'h0000;
      dac_q      <= 16'h0000;
      dac_valid  <= 1'b0;
      stuff_pend <= 1'b0;
    end
    else
    begin
      dac_i      <= next_dac_i;
      dac_q      <= next_dac_q;
      dac_valid  <= next_dac_valid;
      stuff_pend <= next_stuff_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_dual_capture: assert property (rstn && pair_tick |=> filt_valid
    && filt_i == $past(a_s3) && filt_q == $past(b_s3))
    else $error("dual port pair not captured");
  a_rate_clamp: assert property (one_port |-> interp_sel != 2'h0)
    else $error("1x rate used in single port");
  a_div_phase: assert property (!pll_on && pair_tick |-> div_cnt == 5'h00)
    else $error("divided capture off phase");
  a_ratio_value: assert property (dac_ratio == (5'h01 << interp_sel) << zstuff)
    else $error("output ratio wrong");
  a_q_pairs_i: assert property (word_tick && is_q && !reg_port[0] |=> filt_valid
    && filt_q == $past(a_s3) && filt_i == $past(hold_i)) else $error("I first pairing");
  a_sel_route: assert property (word_tick && !is_q && !reg_port[0] |=>
    hold_i == $past(a_s3) && !filt_valid) else $error("I word not held");
  a_stuff_mid: assert property (zstuff && chain_valid ##1 !chain_valid |=>
    dac_valid && dac_i == dac_port_pkg::MIDSCALE) else $error("no midscale");
  a_lock_route: assert property (pll_on && !reg_interp[0] && !redirect
    |=> sample_rate_clock_out == $past(pll_lock)) else $error("lock not on pin");
  a_sdo_route: assert property (redirect |=> sdo_oe && !sample_rate_clock_out)
    else $error("clock not moved to serial pin");
  a_word_clock: assert property (word_tick |=> interleaved_clock_out
    != reg_port[2]) else $error("interleaved clock level wrong");

  c_dual_pll: cover property (pll_on && !one_port && pair_tick);
  c_one_port_pair: cover property (one_port && filt_valid);
  c_stuff: cover property (dac_valid && dac_i == dac_port_pkg::MIDSCALE);
  c_write_resp: cover property (bvalid && s_axi_bready);
endmodule // dac_input_port
`default_nettype wire

// file: rtl/dac_port_pkg.sv
// Shared constants for the converter input port and clocking block
`default_nettype none
package dac_port_pkg;
  // Sample word width
  localparam int          DATA_W      = 16;
  // Register indices; the byte address is four times the index
  localparam logic [5:0]  IDX_INTERP  = 6'h01;
  localparam logic [5:0]  IDX_PORT    = 6'h02;
  localparam logic [5:0]  IDX_SDO     = 6'h03;
  localparam logic [5:0]  IDX_PLL     = 6'h04;
  localparam logic [5:0]  IDX_STATUS  = 6'h05;
  // Field positions, interpolation register
  localparam int          INTERP_LO   = 6;
  localparam int          ZSTUFF_BIT  = 3;
  localparam int          CLKSEL_BIT  = 0;
  // Field positions, port register
  localparam int          ONEPORT_BIT = 6;
  localparam int          DCLKINV_BIT = 4;
  localparam int          WCLKINV_BIT = 2;
  localparam int          SELINV_BIT  = 1;
  localparam int          PAIR_BIT    = 0;
  // Field positions, output routing and multiplier registers
  localparam int          SDO_BIT     = 7;
  localparam int          PLL_BIT     = 7;
  // Register reset value
  localparam logic [7:0]  REG_RESET   = 8'h00;
  // Interpolation codes
  localparam logic [1:0]  RATE_1X     = 2'h0;
  localparam logic [1:0]  RATE_2X     = 2'h1;
  localparam logic [1:0]  RATE_4X     = 2'h2;
  localparam logic [1:0]  RATE_8X     = 2'h3;
  // Midscale word inserted by zero stuffing
  localparam logic [15:0] MIDSCALE    = 16'h8000;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: rtl/sync_if.sv
// Carrier between the block and its pin synchronisers
`default_nettype none
interface sync_if;
  logic raw;    // Pin level, unsynchronised
  logic clean;  // Filtered level
  // Synchroniser side
  modport syncer (input raw, output clean);
  // User side
  modport user (output raw, input clean);
endinterface
`default_nettype wire

// file: rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module pin_sync
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Pin and filtered level
  sync_if.syncer   port
);
  logic [2:0] stages;       // Flop chain, stage 0 first
  logic [2:0] next_stages;  // Next chain value
  logic       level;        // Accepted level
  logic       next_level;   // Next accepted level

  // Shift and accept once stages one and two agree
  always_comb
  begin
    next_stages = {stages[1:0], port.raw};
    next_level  = level;
    if (stages[1] == stages[2])
    begin
      next_level = stages[2];
    end
  end

  // Register only
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      stages <= 3'h0;
      level  <= 1'b0;
    end
    else
    begin
      stages <= next_stages;
      level  <= next_level;
    end
  end

  assign port.clean = level;
endmodule // pin_sync
`default_nettype wire

// file: tb/tx_source.sv
// Behavioural transmit source driving sample words and the converter clock pin
`default_nettype none
module tx_source
(
  // Clock and enable
  input  wire logic   clock,
  input  wire logic   run,
  // Sample pins
  output logic [15:0] port_a_data,
  output logic [15:0] port_b_data,
  output logic        converter_clock_input,
  output logic        channel_select
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0]  phase = 2'h0;   // Cycle within a half period
  logic [15:0] word  = 16'h0;  // Current word, low bit marks Q
  logic        pin   = 1'b0;   // Converter clock level
  always @(posedge clock)
  begin
    if (run)
    begin
      phase <= phase + 2'h1;
      if (phase == 2'h3)
        pin <= !pin;
      if (phase == 2'h1)
        word <= {word[15:1] + {14'h0, !pin}, pin};
    end
  end
  assign channel_select        = word[0];
  assign port_a_data           = word;
  assign port_b_data           = ~word;
  assign converter_clock_input = pin;
endmodule // tx_source
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the converter input port block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0] OK = dac_port_pkg::RESP_OKAY;
  // Design and partner pins
  logic        clock, rstn, run, pll_lock, chain_valid, filt_valid, dac_valid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, interp_sel;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] port_a_data, port_b_data, filt_i, filt_q, chain_i, chain_q, dac_i, dac_q;
  logic        converter_clock_input, channel_select, sdo_out, sdo_oe;
  logic        sample_rate_clock_out, interleaved_clock_out;
  logic [4:0]  dac_ratio;
  // Bench state
  logic        watch_ilv, ilv_inv, strobe;
  int          err_total, num_checks, t;
  // Pulse being timed
  assign strobe = watch_ilv ? (interleaved_clock_out ^ ilv_inv) : filt_valid;
  dac_input_port uut (.*);
  tx_source src (.*);
  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bus write, each channel released when taken
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw;
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {ta, tw} = 2'h0;
    while (!(ta && tw))
    begin
      @(negedge clock);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge clock); while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask
  // Bus read
  task automatic axr(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    @(posedge clock);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(negedge clock); while (!s_axi_arready);
    @(posedge clock);
    s_axi_arvalid <= 1'b0;
    do @(negedge clock); while (!s_axi_rvalid);
    chk(s_axi_rresp, er);
    if (er == OK) chk(s_axi_rdata, {24'h0, exp});
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask
  // Configure, then time pulses and check captured pairs
  task automatic mode(input logic [7:0] ir, pr, rr, input logic pll, input int gap,
                      input logic ilv, pin);
    axw(8'h04, ir, OK);
    axw(8'h08, pr, OK);
    axw(8'h0C, rr, OK);
    axw(8'h10, {pll, 7'h0}, OK);
    {run, watch_ilv, ilv_inv} <= {pll, ilv, pr[2]};
    repeat (40) @(posedge clock);
    for (int n = 0; n < 5; n++)
    begin
      t = 0;
      do @(negedge clock); while (!strobe && ++t < 99);
      if (n > 0) chk(t + 1, gap);
      if (!ilv && !pr[6])
      begin
        chk(filt_q, {16'h0, ~filt_i});
        chk(rr[7] ? {sdo_out, sdo_oe} : {sample_rate_clock_out, 1'b1}, {pin, 1'b1});
      end
      if (!ilv && pll) chk(filt_i[0], pr[6] & pr[1]);
      if (!ilv && pll && pr[6]) chk(pr[0] ? filt_i - filt_q : filt_q - filt_i, 1);
    end
    $display("mode %h %h done", ir, pr);
  endtask
  // Verdict
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rstn, run, chain_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, watch_ilv, ilv_inv, chain_i, chain_q} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_wstrb, pll_lock, err_total, num_checks} = {5'h1F, 64'h0};
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 1; i < 5; i++) axr(8'(i * 4), dac_port_pkg::REG_RESET, OK);
    axw(8'h14, 8'hFF, OK);
    axr(8'h14, 8'h81, OK);
    axr(8'h3C, 8'h00, dac_port_pkg::RESP_SLVERR);
    $display("registers done");
    for (int c = 0; c < 8; c++)
    begin
      axw(8'h04, {c[1:0], 2'h0, c[2], 3'h0}, OK);
      chk(dac_ratio, (32'h1 << c[1:0]) << c[2]);
      chk(interp_sel, c[1:0]);
    end
    axw(8'h08, 8'h40, OK);
    axw(8'h04, 8'h00, OK);
    chk(interp_sel, dac_port_pkg::RATE_2X);
    $display("rates done");
    mode(8'h48, 8'h00, 8'h80, 1'b0, 4, 1'b0, 1'b1);
    mode(8'hC0, 8'h10, 8'h00, 1'b0, 8, 1'b0, 1'b0);
    mode(8'h41, 8'h00, 8'h00, 1'b1, 8, 1'b0, 1'b1);
    @(posedge clock);
    pll_lock <= 1'b0;
    mode(8'h40, 8'h00, 8'h00, 1'b1, 8, 1'b0, 1'b0);
    for (int p = 0; p < 4; p++) mode(8'h40, 8'h40 | 8'(p), 8'h00, 1'b1, 8, 1'b0, 1'b0);
    mode(8'hC0, 8'h44, 8'h00, 1'b0, 4, 1'b1, 1'b0);
    axw(8'h04, 8'h48, OK);
    @(posedge clock);
    {chain_i, chain_q, chain_valid} <= {32'h1357ACE0, 1'b1};
    @(posedge clock);
    chain_valid <= 1'b0;
    t = 0;
    do @(negedge clock); while (!dac_valid && ++t < 8);
    chk({dac_i, dac_q}, 32'h1357ACE0);
    @(negedge clock);
    chk(dac_valid, 1);
    chk({dac_i, dac_q}, {2{dac_port_pkg::MIDSCALE}});
    $display("stuffing done");
    report_and_stop();
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clock);
    err_total++;
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
